// ===== pkg/rct_pkg.sv
// Function
// - stop-on-receive halts count after four received bits
// - stop-on-receive ignored in trimming modes
// - start select 00: no automatic start
// - start select 01: start at transmission end
// - start select 10: trimming, no underflow
// - start select 11: trimming, underflow allowed
// - auto reload: reload at zero, keep counting, except start select 10 holds at zero
// - no auto reload: stop at zero
// - every underflow sets the interrupt flag
// - clock select picks the decrement source
// - start event loads counter from reload bytes, unless a stop event comes in the same cycle
// - reload writes act only at next start or auto reload
// - neighbour count readable as two bytes
package rct_pkg;
	localparam logic [7:0] ADDR_NB_HIGH   = 8'h1c;
	localparam logic [7:0] ADDR_NB_LOW    = 8'h1d;
	localparam logic [7:0] ADDR_CONTROL   = 8'h1e;
	localparam logic [7:0] ADDR_RELOAD_HI = 8'h1f;
	localparam logic [7:0] ADDR_RELOAD_LO = 8'h20;
	localparam logic [7:0] ADDR_COUNT_HI  = 8'h21;
	localparam logic [7:0] ADDR_COUNT_LO  = 8'h22;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h40;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h41;
	localparam logic [7:0] ADDR_CMD       = 8'h42;

	localparam int STOP_RX_BIT   = 7;
	localparam int START_LSB     = 4;
	localparam int RESTART_BIT   = 3;
	localparam int CLKSEL_LSB    = 0;
	localparam logic [7:0] CONTROL_WMASK = 8'hbb;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET  = 8'h00;

	localparam int IRQ_UNDERFLOW = 0;
	localparam int IRQ_RX_STOP   = 1;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT  = 1;

	localparam int RX_STOP_BITS = 4;

	// tick rates, fast in kHz and slow in Hz, derived from the 250 MHz system clock
	localparam int CLK_KHZ        = 250000;
	localparam int FAST_TICK_KHZ  = 13560;
	localparam int SLOW_TICK_HZ   = 211875;
	localparam int FAST_DIV = CLK_KHZ / FAST_TICK_KHZ;
	localparam int SLOW_DIV = (CLK_KHZ * 1000) / SLOW_TICK_HZ;

	typedef enum logic [1:0] {
		START_NONE,
		START_TX_END,
		START_TRIM,
		START_TRIM_UF
	} rct_start_e;

	typedef enum logic [1:0] {
		CLK_FAST,
		CLK_SLOW,
		CLK_TIMER0,
		CLK_TIMER1
	} rct_clk_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rct_bus_s;

	typedef struct packed {
		logic tx_end;
		logic rx_bit;
		logic rx_active;
		logic lfo_edge;
		logic timer0_uf;
		logic timer1_uf;
	} rct_event_s;
endpackage

// ===== hdl/rct_timer.sv
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module rct_timer
	import rct_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire rct_bus_s    bus,
	output logic      [7:0]  rdata,
	input  wire rct_event_s  events,
	input  wire logic [15:0] neighbour_count,
	output logic             underflow,
	output logic             running,
	output logic             irq
);
	typedef struct packed {
		logic [7:0]  control;
		logic [7:0]  reload_high_byte;
		logic [7:0]  reload_low_byte;
		logic [15:0] count;
		logic        running;
		logic        trim_phase;
		logic [2:0]  rx_bits;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		logic [7:0]  rdata;
		logic        underflow;
		logic [15:0] fast_cnt;
		logic [15:0] slow_cnt;
	} rct_state_s;

	rct_state_s state;
	rct_state_s next_state;
	logic [1:0] rst_sync;
	logic       srst_n;

	function automatic logic [7:0] read_mux(input rct_state_s s, input logic [7:0] a,
			input logic [15:0] nb);
		case (a)
			ADDR_NB_HIGH:   read_mux = nb[15:8];
			ADDR_NB_LOW:    read_mux = nb[7:0];
			ADDR_CONTROL:   read_mux = s.control;
			ADDR_RELOAD_HI: read_mux = s.reload_high_byte;
			ADDR_RELOAD_LO: read_mux = s.reload_low_byte;
			ADDR_COUNT_HI:  read_mux = s.count[15:8];
			ADDR_COUNT_LO:  read_mux = s.count[7:0];
			ADDR_IRQ_STAT:  read_mux = {6'h0, s.irq_status};
			ADDR_IRQ_MASK:  read_mux = {6'h0, s.irq_mask};
			ADDR_CMD:       read_mux = {7'h0, s.running};
			default:        read_mux = 8'h00;
		endcase
	endfunction

	// reset release is synchronised so all flops leave reset on one edge;
	// kept outside the state struct so that struct has a single driver
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign srst_n = rst_sync[1];

	logic        stop_rx;
	logic        auto_restart;
	rct_start_e  start_sel;
	rct_clk_e    clk_sel;
	logic        trim_mode;
	logic        tick;
	logic        start_evt;
	logic        stop_evt;
	logic        fast_tick;
	logic        slow_tick;
	logic [15:0] reload_value;

	always_comb begin
		stop_rx      = state.control[STOP_RX_BIT];
		auto_restart = state.control[RESTART_BIT];
		start_sel    = rct_start_e'(state.control[START_LSB +: 2]);
		clk_sel      = rct_clk_e'(state.control[CLKSEL_LSB +: 2]);
		trim_mode    = (start_sel == START_TRIM) || (start_sel == START_TRIM_UF);
		reload_value = {state.reload_high_byte, state.reload_low_byte};
		fast_tick    = (state.fast_cnt == 16'(FAST_DIV - 1));
		slow_tick    = (state.slow_cnt == 16'(SLOW_DIV - 1));
		case (clk_sel)
			CLK_FAST:   tick = fast_tick;
			CLK_SLOW:   tick = slow_tick;
			CLK_TIMER0: tick = events.timer0_uf;
			CLK_TIMER1: tick = events.timer1_uf;
			default:    tick = 1'b0;
		endcase
		start_evt = 1'b0;
		stop_evt  = 1'b0;
		case (start_sel)
			START_NONE:   start_evt = 1'b0;
			START_TX_END: start_evt = events.tx_end;
			START_TRIM, START_TRIM_UF: begin
				// trimming: first lfo edge starts, next one stops
				start_evt = events.lfo_edge && !state.trim_phase;
				stop_evt  = events.lfo_edge && state.trim_phase;
			end
			default: start_evt = 1'b0;
		endcase
		if (bus.wr && bus.addr == ADDR_CMD) begin
			start_evt = start_evt | bus.wdata[CMD_START_BIT];
			stop_evt  = stop_evt | bus.wdata[CMD_STOP_BIT];
		end
	end

	logic rx_stop;
	assign rx_stop = stop_rx && !trim_mode && state.running && events.rx_bit
		&& (state.rx_bits == 3'(RX_STOP_BITS - 1));

	always_comb begin
		next_state           = state;
		next_state.underflow = 1'b0;
		next_state.rdata     = 8'h00;
		next_state.fast_cnt  = fast_tick ? 16'h0000 : state.fast_cnt + 16'h0001;
		next_state.slow_cnt  = slow_tick ? 16'h0000 : state.slow_cnt + 16'h0001;

		if (!events.rx_active) begin
			next_state.rx_bits = 3'h0;
		end else if (events.rx_bit && state.rx_bits != 3'(RX_STOP_BITS)) begin
			next_state.rx_bits = state.rx_bits + 3'h1;
		end

		if (bus.rd) begin
			next_state.rdata = read_mux(state, bus.addr, neighbour_count);
		end
		if (bus.wr) begin
			case (bus.addr)
				ADDR_CONTROL:   next_state.control = bus.wdata & CONTROL_WMASK;
				ADDR_RELOAD_HI: next_state.reload_high_byte = bus.wdata;
				ADDR_RELOAD_LO: next_state.reload_low_byte = bus.wdata;
				ADDR_IRQ_MASK:  next_state.irq_mask = bus.wdata[1:0];
				ADDR_IRQ_STAT:  next_state.irq_status = state.irq_status & ~bus.wdata[1:0];
				default: ;
			endcase
		end

		if (state.running && tick) begin
			if (state.count == 16'h0000) begin
				// in plain trim mode an underflow is suppressed and the count holds
				if (start_sel != START_TRIM) begin
					next_state.underflow = 1'b1;
					next_state.irq_status[IRQ_UNDERFLOW] = 1'b1;
					if (auto_restart) begin
						next_state.count = reload_value;
					end else begin
						next_state.running = 1'b0;
					end
				end
			end else begin
				next_state.count = state.count - 16'h0001;
			end
		end

		if (rx_stop) begin
			next_state.running = 1'b0;
			next_state.irq_status[IRQ_RX_STOP] = 1'b1;
		end
		if (stop_evt) begin
			next_state.running    = 1'b0;
			next_state.trim_phase = 1'b0;
		end else if (start_evt) begin
			next_state.count      = reload_value;
			next_state.running    = 1'b1;
			next_state.trim_phase = trim_mode;
		end
		if (!trim_mode) begin
			next_state.trim_phase = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			state.control          <= CONTROL_RESET;
			state.reload_high_byte <= RELOAD_RESET;
			state.reload_low_byte  <= RELOAD_RESET;
			state.count            <= 16'h0000;
			state.running          <= 1'b0;
			state.trim_phase       <= 1'b0;
			state.rx_bits          <= 3'h0;
			state.irq_status       <= 2'h0;
			state.irq_mask         <= 2'h0;
			state.rdata            <= 8'h00;
			state.underflow        <= 1'b0;
			state.fast_cnt         <= 16'h0000;
			state.slow_cnt         <= 16'h0000;
		end else begin
			state.control          <= next_state.control;
			state.reload_high_byte <= next_state.reload_high_byte;
			state.reload_low_byte  <= next_state.reload_low_byte;
			state.count            <= next_state.count;
			state.running          <= next_state.running;
			state.trim_phase       <= next_state.trim_phase;
			state.rx_bits          <= next_state.rx_bits;
			state.irq_status       <= next_state.irq_status;
			state.irq_mask         <= next_state.irq_mask;
			state.rdata            <= next_state.rdata;
			state.underflow        <= next_state.underflow;
			state.fast_cnt         <= next_state.fast_cnt;
			state.slow_cnt         <= next_state.slow_cnt;
		end
	end

	assign rdata     = state.rdata;
	assign underflow = state.underflow;
	assign running   = state.running;
	assign irq       = |(state.irq_status & state.irq_mask);
endmodule

// ===== verification/rct_timer_checker.sv
`timescale 1ns/10ps
module rct_timer_checker
	import rct_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire rct_bus_s    bus,
	input wire logic [7:0]  rdata,
	input wire rct_event_s  events,
	input wire logic [15:0] neighbour_count,
	input wire logic        underflow,
	input wire logic        running
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_rd(logic [7:0] a);
		bus.rd && bus.addr == a;
	endsequence
	sequence s_cmd(logic [1:0] v);
		bus.wr && bus.addr == ADDR_CMD && bus.wdata[1:0] == v;
	endsequence
	a_nb_high_read: assert property (s_rd(ADDR_NB_HIGH) |=> rdata == $past(neighbour_count[15:8]))
		else $error("neighbour high byte wrong");
	a_nb_low_read: assert property (s_rd(ADDR_NB_LOW) |=> rdata == $past(neighbour_count[7:0]))
		else $error("neighbour low byte wrong");
	a_unmapped_read: assert property (bus.rd && !(bus.addr inside {[8'h1c:8'h22], [8'h40:8'h42]})
		|=> rdata == 8'h00) else $error("unmapped read not zero");
	a_ctrl_reserved: assert property (s_rd(ADDR_CONTROL) |=> rdata[6] == 1'b0 && rdata[2] == 1'b0)
		else $error("reserved control bits set");
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	a_cmd_stop: assert property (s_cmd(2'b10) |=> !running)
		else $error("stop command ignored");
	a_cmd_start: assert property (s_cmd(2'b01) ##0 !running && !events.rx_bit |=> running)
		else $error("start command ignored");
	a_uf_single: assert property (underflow |-> $past(running) ##1 !underflow)
		else $error("underflow pulse malformed");
endmodule

bind rct_timer rct_timer_checker rct_timer_checker_i (.clock(clock), .rst_n(rst_n), .bus(bus),
	.rdata(rdata), .events(events), .neighbour_count(neighbour_count), .underflow(underflow),
	.running(running));

// ===== verification/rct_timer_bench.sv
`timescale 1ns/10ps
module rct_timer_bench
	import rct_pkg::*;
;
	localparam int EV_TX = 5;
	localparam int EV_RX = 4;
	localparam int EV_LF = 2;
	localparam int EV_T0 = 1;
	localparam int EV_T1 = 0;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	rct_bus_s    bus = '0;
	rct_event_s  events = '0;
	logic [15:0] neighbour_count = '0;
	logic [7:0]  rdata;
	logic        underflow;
	logic        running;
	logic        irq;
	int          mismatches = 0;
	int          compares = 0;
	int          uf_seen = 0;
	logic [15:0] rl;
	logic [15:0] c;
	logic [7:0]  d;

	rct_timer rct_timer_i (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.events(events), .neighbour_count(neighbour_count), .underflow(underflow),
		.running(running), .irq(irq));

	initial begin
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		if (underflow === 1'b1) uf_seen++;
	end

	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		compares++;
		if (e !== g) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask
	// count bytes are not latched together, so reads assume no tick in between
	task automatic cnt();
		rd(ADDR_COUNT_HI, c[15:8]);
		rd(ADDR_COUNT_LO, c[7:0]);
	endtask
	task automatic ev(int b, int n);
		repeat (n) begin
			@(posedge clock);
			events[b] <= 1'b1;
			@(posedge clock);
			events[b] <= 1'b0;
		end
		#1;
	endtask
	function automatic logic [15:0] after(logic [15:0] r, int n, bit ar);
		logic [15:0] v;
		v = r;
		repeat (n) v = (v != 0) ? v - 1'b1 : (ar ? r : 16'h0000);
		return v;
	endfunction
	// free-running tick dividers leave the tick phase unknown
	function automatic bit dec_ok(logic [15:0] dv, int s);
		case (s)
			0: return dv inside {1, 2};
			1: return dv inside {0, 1};
			2: return dv == 3;
			default: return dv == 2;
		endcase
	endfunction
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		final_report();
	end

	initial begin
		void'($urandom(10717));
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		neighbour_count <= 16'($urandom);
		rd(ADDR_CONTROL, d);
		chk("control", 8'h00, d);
		rd(ADDR_NB_HIGH, d);
		chk("nb_high", neighbour_count[15:8], d);
		rd(ADDR_NB_LOW, d);
		chk("nb_low", neighbour_count[7:0], d);
		rd(8'h30, d);
		chk("unmapped", 8'h00, d);
		$display("test regs done");
		rl = 16'($urandom_range(16'hffff, 16'h0100));
		wr(ADDR_CONTROL, 8'h0a);
		wr(ADDR_RELOAD_HI, rl[15:8]);
		wr(ADDR_RELOAD_LO, rl[7:0]);
		wr(ADDR_CMD, 8'h01);
		cnt();
		chk("start_load", rl, c);
		wr(ADDR_RELOAD_HI, 8'h00);
		ev(EV_T0, 5);
		cnt();
		chk("no_disturb", after(rl, 5, 1'b1), c);
		wr(ADDR_RELOAD_LO, 8'h02);
		wr(ADDR_IRQ_MASK, 8'h01);
		wr(ADDR_CMD, 8'h01);
		uf_seen = 0;
		ev(EV_T0, 4);
		cnt();
		chk("auto_reload", after(16'h0002, 4, 1'b1), c);
		chk("uf_pulse", 1, uf_seen);
		chk("irq_set", 1, irq);
		wr(ADDR_IRQ_STAT, 8'h01);
		chk("irq_clear", 0, irq);
		wr(ADDR_CONTROL, 8'h02);
		wr(ADDR_CMD, 8'h01);
		ev(EV_T0, 4);
		chk("stop_at_zero", 0, running);
		$display("test underflow done");
		for (int m = 0; m < 2; m++) begin
			wr(ADDR_CMD, 8'h02);
			wr(ADDR_CONTROL, {2'b00, 2'(m), 4'h2});
			ev(EV_TX, 1);
			chk("tx_start", m, running);
		end
		wr(ADDR_RELOAD_LO, 8'h01);
		for (int m = 1; m < 4; m++) begin
			wr(ADDR_CMD, 8'h02);
			wr(ADDR_CONTROL, {2'b10, 2'(m), 4'ha});
			uf_seen = 0;
			ev(m == 1 ? EV_TX : EV_LF, 1);
			events.rx_active <= 1'b1;
			ev(EV_RX, 3);
			chk("rx_three", 1, running);
			ev(EV_RX, 1);
			chk("rx_four", m != 1, running);
			events.rx_active <= 1'b0;
			if (m > 1) begin
				ev(EV_T0, 3);
				chk("trim_uf", m == 3, uf_seen);
				ev(EV_LF, 1);
				chk("trim_stop", 0, running);
			end
		end
		$display("test start modes done");
		wr(ADDR_RELOAD_HI, 8'h01);
		wr(ADDR_RELOAD_LO, 8'h80);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_CONTROL, {6'h02, 2'(s)});
			wr(ADDR_CMD, 8'h01);
			ev(EV_T0, 3);
			ev(EV_T1, 2);
			repeat (20) @(posedge clock);
			cnt();
			chk("clk_sel", 1, dec_ok(16'h0180 - c, s));
		end
		$display("test clock select done");
		final_report();
	end
endmodule
